// ---- bench/reset_strap_sampler_test.sv ----
// Self-checking bench for the strap sampler
module test_reset_strap_sampler;
  import strap_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 4;
  logic i_clk_sys = 1'b0;
  logic i_rstn = 1'b1;
  logic [15:0] val = '0, drv = '0, fo = '0, foe = '0, pin, pout, poe, pu, cfg, want;
  logic rx, vld, ld, p1, p2;
  logic [2:0] pr, cr;
  logic [31:0] seed = 32'h7A00CFF2, r;
  int failures = 0, compares = 0, n;
  reset_strap_sampler #(.HOLD_CYC(HOLD)) reset_strap_sampler_inst (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
    .i_strap_pin_in(pin), .i_func_out(fo), .i_func_oe(foe), .o_strap_pin_out(pout), .o_strap_pin_oe(poe),
    .o_pullup_en(pu), .o_rx_en(rx), .o_cfg(cfg), .o_cfg_valid(vld), .o_cfg_load(ld), .o_plat_ratio(pr),
    .o_core_ratio(cr), .o_serdes1_pwrdn(p1), .o_serdes2_pwrdn(p2));
  strap_board strap_board_inst (.i_val(val), .i_drv(drv), .i_out(pout), .i_oe(poe), .i_pu(pu), .o_pin(pin));
  initial forever #5 i_clk_sys = ~i_clk_sys;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Undriven pulled-up pins read high, the rest take the board level
  function automatic logic [15:0] exp_cfg(input logic [15:0] v, input logic [15:0] d);
    return (v & d) | ~d;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Each pass is a fresh hard reset, so later passes also reset mid-run
  initial begin
    // Falling edge at time zero resets every flop before the first clock
    i_rstn <= 1'b0;
    // Two edges here plus the four of the first pass give the 6-cycle opening reset
    repeat (2) @(posedge i_clk_sys);
    for (int it = 0; it < 10; it++) begin
      r = rnd();
      @(posedge i_clk_sys);
      i_rstn <= 1'b0;
      val <= (it == 0) ? 16'hFFFF : (it == 1) ? 16'h0000 : r[15:0];
      drv <= (it == 0) ? ~PULLUP_MASK : (it == 1) ? 16'hFFFF : (r[31:16] | ~PULLUP_MASK);
      fo <= rnd();
      foe <= 16'hFFFF;
      repeat (3) @(negedge i_clk_sys);
      chk(poe, 16'h0000);
      chk(pu, PULLUP_MASK);
      chk({15'h0, rx}, 16'h0001);
      want = exp_cfg(val, drv);
      @(posedge i_clk_sys);
      i_rstn <= 1'b1;
      @(negedge i_clk_sys);
      for (n = 1; n < 50 && vld !== 1'b1; n++) @(negedge i_clk_sys);
      if (vld !== 1'b1) begin
        failures++;
        $display("[FAIL] %0t capture never came", $time);
        close_out();
      end
      // n is 1 just after the release edge, so capture on edge HOLD reads HOLD + 1
      chk(16'(n), 16'(HOLD + 1));
      chk(cfg, want);
      chk({14'h0, ld, rx}, 16'h0002);
      chk(pu, 16'h0000);
      chk({8'h0, p1, p2, cr, pr}, {8'h0, want[2:0] == 3'h0, want[5:3] == 3'h0, want[11:6]});
      @(posedge i_clk_sys);
      val <= ~val;
      r = rnd();
      fo <= r[15:0];
      foe <= r[31:16];
      repeat (3) @(negedge i_clk_sys);
      chk(cfg, want);
      chk(pout, fo);
      chk(poe, foe);
    end
    close_out();
  end
endmodule

// ---- bench/strap_board.sv ----
// Board strap resistors and pad wire resolution
module strap_board (
  input  wire logic [15:0] i_val,
  input  wire logic [15:0] i_drv,
  input  wire logic [15:0] i_out,
  input  wire logic [15:0] i_oe,
  input  wire logic [15:0] i_pu,
  output logic      [15:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Floating pins show the inverse, so a stale level never reads as good
  always_comb begin
    for (int k = 0; k < 16; k++) begin
      o_pin[k] = i_oe[k] ? i_out[k] : i_drv[k] ? i_val[k] : i_pu[k] ? 1'b1 : ~i_val[k];
    end
  end
endmodule

// ---- bench/strap_sampler_sva.sv ----
// Port checker for the strap sampler
module strap_sampler_chk
  import strap_pkg::*;
#(
  parameter int N_STRAP  = STRAP_W,
  parameter int HOLD_CYC = PULLUP_HOLD_CYC
) (
  input wire logic               i_clk_sys,
  input wire logic               i_rstn,
  input wire logic [N_STRAP-1:0] i_func_out,
  input wire logic [N_STRAP-1:0] i_func_oe,
  input wire logic [N_STRAP-1:0] o_strap_pin_out,
  input wire logic [N_STRAP-1:0] o_strap_pin_oe,
  input wire logic [N_STRAP-1:0] o_pullup_en,
  input wire logic               o_rx_en,
  input wire logic [N_STRAP-1:0] o_cfg,
  input wire logic               o_cfg_valid,
  input wire logic               o_cfg_load,
  input wire logic [2:0]         o_plat_ratio,
  input wire logic [2:0]         o_core_ratio,
  input wire logic               o_serdes1_pwrdn,
  input wire logic               o_serdes2_pwrdn
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk_sys); endclocking
  reset_input_a: assert property (!i_rstn |-> o_rx_en) else $error("receiver off in reset");
  sample_quiet_a: assert property (o_rx_en |-> o_strap_pin_oe == '0) else $error("pad driven while sampling");
  pullup_gate_a: assert property (o_pullup_en == (o_rx_en ? N_STRAP'(PULLUP_MASK) : '0))
    else $error("pull-up enable wrong");
  rx_window_a: assert property (disable iff (!i_rstn) $rose(i_rstn) |-> o_rx_en [*2] ##[1:1000] !o_rx_en)
    else $error("sample window wrong");
  capture_edge_a: assert property (disable iff (!i_rstn)
    $rose(o_cfg_valid) |-> o_cfg_load && !o_rx_en && $past(o_rx_en)) else $error("capture edge wrong");
  load_pulse_a: assert property (o_cfg_load |=> !o_cfg_load) else $error("load not one cycle");
  cfg_hold_a: assert property (disable iff (!i_rstn) o_cfg_valid |=> $stable(o_cfg)) else $error("cfg moved");
  pwrdn_decode_a: assert property (o_cfg_valid |-> o_serdes1_pwrdn == (o_cfg[2:0] == SERDES_PWRDN_CODE)
    && o_serdes2_pwrdn == (o_cfg[5:3] == SERDES_PWRDN_CODE)) else $error("power-down decode wrong");
  ratio_field_a: assert property (o_plat_ratio == o_cfg[8:6] && o_core_ratio == o_cfg[11:9])
    else $error("ratio fields wrong");
  func_path_a: assert property (disable iff (!i_rstn) !o_rx_en && !$past(o_rx_en) |->
    o_strap_pin_out == $past(i_func_out) && o_strap_pin_oe == $past(i_func_oe)) else $error("func path wrong");
endmodule
bind reset_strap_sampler strap_sampler_chk #(.N_STRAP(N_STRAP), .HOLD_CYC(HOLD_CYC)) chk_inst (
  .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_func_out(i_func_out), .i_func_oe(i_func_oe),
  .o_strap_pin_out(o_strap_pin_out), .o_strap_pin_oe(o_strap_pin_oe), .o_pullup_en(o_pullup_en),
  .o_rx_en(o_rx_en), .o_cfg(o_cfg), .o_cfg_valid(o_cfg_valid), .o_cfg_load(o_cfg_load),
  .o_plat_ratio(o_plat_ratio), .o_core_ratio(o_core_ratio),
  .o_serdes1_pwrdn(o_serdes1_pwrdn), .o_serdes2_pwrdn(o_serdes2_pwrdn));

// ---- src/reset_strap_sampler.sv ----
// Power-on strap sampler: pin direction, gated pull-ups and latched configuration
//
// Function
// - Strap pins are inputs, output drivers off, while hard reset is held.
// - Pin levels are captured when the window after reset release closes and kept as configuration.
// - After release the receiver turns off and pins follow functional outputs.
// - Gated pull-up on during reset and a few cycles after release.
// - Pull-up is off whenever the strap receiver is off.
// - A sampled high selects the default; low picks a non-default setting.
// - Platform and core clock ratio pins never get the gated pull-up.
// - First transceiver select field can power down the first transceiver.
// - Second transceiver protocol field can power down the second transceiver.
//
// The window lasts HOLD_CYC clocks after release, never fewer than the
// synchroniser depth plus one. The word kept is the pin level two clocks
// before the window closes, so straps must stay steady until then.
module reset_strap_sampler
  import strap_pkg::*;
#(
  parameter int N_STRAP  = STRAP_W,
  parameter int HOLD_CYC = PULLUP_HOLD_CYC
) (
  input  wire logic               i_clk_sys,
  input  wire logic               i_rstn,
  input  wire logic [N_STRAP-1:0] i_strap_pin_in,
  input  wire logic [N_STRAP-1:0] i_func_out,
  input  wire logic [N_STRAP-1:0] i_func_oe,
  output logic      [N_STRAP-1:0] o_strap_pin_out,
  output logic      [N_STRAP-1:0] o_strap_pin_oe,
  output logic      [N_STRAP-1:0] o_pullup_en,
  output logic                    o_rx_en,
  output logic      [N_STRAP-1:0] o_cfg,
  output logic                    o_cfg_valid,
  output logic                    o_cfg_load,
  output logic      [FIELD3_W-1:0] o_plat_ratio,
  output logic      [FIELD3_W-1:0] o_core_ratio,
  output logic                    o_serdes1_pwrdn,
  output logic                    o_serdes2_pwrdn
);

  // Capture cannot precede the synchroniser filling after release
  localparam int HOLD_MIN = SYNC_STAGES + 1;
  localparam int HOLD_EFF = (HOLD_CYC < HOLD_MIN) ? HOLD_MIN : HOLD_CYC;
  // Counter just wide enough to reach the window length
  localparam int CNT_W    = $clog2(HOLD_EFF + 1);
  // Count seen on the capture edge
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HOLD_EFF - 1);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

  // Two phases only: the strap window and normal running
  typedef enum logic [0:0] {
    ST_SAMPLE,
    ST_RUN
  } phase_t;

  // Power-down request from a three-bit strap field
  function automatic logic pwrdn_req(input logic [FIELD3_W-1:0] field);
    pwrdn_req = (field == SERDES_PWRDN_CODE);
  endfunction

  logic [N_STRAP-1:0]  pin_sync;

  // Sequencer state
  phase_t              phase_r;
  phase_t              phase_nxt;
  logic [CNT_W-1:0]    cnt_r;
  logic [CNT_W-1:0]    cnt_nxt;
  logic [N_STRAP-1:0]  pullup_r;
  logic [N_STRAP-1:0]  pullup_nxt;
  logic                rx_en_r;
  logic                rx_en_nxt;

  // Pad drivers
  logic [N_STRAP-1:0]  pin_out_r;
  logic [N_STRAP-1:0]  pin_out_nxt;
  logic [N_STRAP-1:0]  pin_oe_r;
  logic [N_STRAP-1:0]  pin_oe_nxt;

  // Captured configuration
  logic [N_STRAP-1:0]  cfg_r;
  logic [N_STRAP-1:0]  cfg_nxt;
  logic                cfg_valid_r;
  logic                cfg_valid_nxt;
  logic                cfg_load_r;
  logic                cfg_load_nxt;
  logic                s1_pwrdn_r;
  logic                s1_pwrdn_nxt;
  logic                s2_pwrdn_r;
  logic                s2_pwrdn_nxt;

  // Decode shared by the groups
  logic                capture_now;
  logic                run_phase;

  // Pins come from the board, so they cross into the clock domain first
  strap_sync #(
    .WIDTH     (N_STRAP)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_async   (i_strap_pin_in),
    .o_sync    (pin_sync)
  );

  // Capture fires on the last count of the sample window
  assign capture_now = (phase_r == ST_SAMPLE) && (cnt_r == CNT_LAST);
  assign run_phase   = (phase_r == ST_RUN);

  // Sequencer: counts the window after release, then hands the pads over
  always_comb begin
    phase_nxt  = phase_r;
    cnt_nxt    = cnt_r;
    pullup_nxt = pullup_r;
    rx_en_nxt  = rx_en_r;
    case (phase_r)
      ST_SAMPLE: begin
        // Pull-up still on here so the level settles before capture
        cnt_nxt = cnt_r + CNT_ONE;
        if (capture_now) begin
          // Receiver and pull-up drop in the same cycle
          rx_en_nxt  = 1'b0;
          pullup_nxt = '0;
          phase_nxt  = ST_RUN;
        end
      end
      ST_RUN: begin
        // Held off every cycle; only a new hard reset reopens the window
        rx_en_nxt  = 1'b0;
        pullup_nxt = '0;
      end
      default: begin
        // An illegal phase falls back to sampling rather than locking up
        phase_nxt = ST_SAMPLE;
      end
    endcase
  end

  // Reset state is the strap window: receiver on, masked pull-ups
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      phase_r  <= ST_SAMPLE;
      cnt_r    <= '0;
      pullup_r <= PULLUP_MASK[N_STRAP-1:0];
      rx_en_r  <= 1'b1;
    end else begin
      phase_r  <= phase_nxt;
      cnt_r    <= cnt_nxt;
      pullup_r <= pullup_nxt;
      rx_en_r  <= rx_en_nxt;
    end
  end

  // Pads: drivers off while sampling, functional data once running
  always_comb begin
    pin_out_nxt = '0;
    pin_oe_nxt  = '0;
    if (run_phase) begin
      // Functional path adds one flop of latency on the pad outputs
      pin_out_nxt = i_func_out;
      pin_oe_nxt  = i_func_oe;
    end
  end

  // Drivers reset off so the strap resistors are never fought in reset
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_out_r <= '0;
      pin_oe_r  <= '0;
    end else begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r  <= pin_oe_nxt;
    end
  end

  // Configuration: loaded once per reset, frozen afterwards
  always_comb begin
    cfg_nxt       = cfg_r;
    cfg_valid_nxt = cfg_valid_r;
    cfg_load_nxt  = 1'b0;
    s1_pwrdn_nxt  = s1_pwrdn_r;
    s2_pwrdn_nxt  = s2_pwrdn_r;
    if (capture_now) begin
      cfg_nxt       = pin_sync;
      cfg_valid_nxt = 1'b1;
      cfg_load_nxt  = 1'b1;
      s1_pwrdn_nxt  = pwrdn_req(pin_sync[SERDES1_SEL_LSB +: FIELD3_W]);
      s2_pwrdn_nxt  = pwrdn_req(pin_sync[SERDES2_PROTO_LSB +: FIELD3_W]);
    end
  end

  // All-ones default until capture; valid stays low so users wait for load
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_r       <= CFG_RESET_VAL[N_STRAP-1:0];
      cfg_valid_r <= 1'b0;
      cfg_load_r  <= 1'b0;
      s1_pwrdn_r  <= 1'b0;
      s2_pwrdn_r  <= 1'b0;
    end else begin
      cfg_r       <= cfg_nxt;
      cfg_valid_r <= cfg_valid_nxt;
      cfg_load_r  <= cfg_load_nxt;
      s1_pwrdn_r  <= s1_pwrdn_nxt;
      s2_pwrdn_r  <= s2_pwrdn_nxt;
    end
  end

  // All outputs straight from flops
  assign o_strap_pin_out = pin_out_r;
  assign o_strap_pin_oe  = pin_oe_r;
  assign o_pullup_en     = pullup_r;
  assign o_rx_en         = rx_en_r;
  assign o_cfg           = cfg_r;
  assign o_cfg_valid     = cfg_valid_r;
  assign o_cfg_load      = cfg_load_r;
  assign o_plat_ratio    = cfg_r[PLAT_RATIO_LSB +: FIELD3_W];
  assign o_core_ratio    = cfg_r[CORE_RATIO_LSB +: FIELD3_W];
  assign o_serdes1_pwrdn = s1_pwrdn_r;
  assign o_serdes2_pwrdn = s2_pwrdn_r;

endmodule

// ---- src/strap_pkg.sv ----
// Shared constants for the power-on strap sampler
package strap_pkg;

  // Pin count and field layout of the captured strap word
  localparam int STRAP_W            = 16;
  localparam int SERDES1_SEL_LSB    = 0;
  localparam int SERDES2_PROTO_LSB  = 3;
  localparam int PLAT_RATIO_LSB     = 6;
  localparam int CORE_RATIO_LSB     = 9;
  localparam int GENERIC_LSB        = 12;
  localparam int FIELD3_W           = 3;
  localparam int GENERIC_W          = 4;

  // Undriven pulled-up pins read high, so the default word is all ones
  localparam logic [STRAP_W-1:0] CFG_RESET_VAL = 16'hFFFF;

  // Clock ratio pins carry no gated pull-up; all others do
  localparam logic [STRAP_W-1:0] PULLUP_MASK   = 16'hF03F;

  // Three-bit code that requests a transceiver power-down
  localparam logic [FIELD3_W-1:0] SERDES_PWRDN_CODE = 3'h0;

  // Platform cycles the pull-up stays on after reset release
  localparam int PULLUP_HOLD_CYC = 8;

  // Synchroniser depth on the strap pins; capture must wait for it
  localparam int SYNC_STAGES = 2;

endpackage

// ---- src/strap_sync.sv ----
// Two-stage synchroniser for the strap pins
module strap_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rstn,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  // First stage feeds only the second stage
  always_comb begin
    meta_nxt = i_async;
    sync_nxt = meta_r;
  end

  // Reset to ones, matching the pulled-up idle level
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign o_sync = sync_r;

endmodule
